// ### logic/bpc_pkg.sv
package bpc_pkg;

    // Register byte addresses.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CFG  = 8'h04;
    localparam logic [7:0] A_RX   = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;

    // Field positions.
    localparam int CTRL_FIN  = 8;
    localparam int ST_STATE  = 4;
    localparam int ST_ERASED = 8;
    localparam int ST_SAD    = 9;
    localparam int ST_LOCKED = 10;
    localparam int ST_READY  = 11;

    // Packet bytes.
    localparam logic [7:0] MARK_START = 8'h81;
    localparam logic [7:0] MARK_END   = 8'h03;
    localparam logic [7:0] RES_ERR    = 8'hff;
    localparam logic [7:0] AREA_PROT  = 8'h01;
    localparam logic [7:0] AREA_PBP   = 8'h02;
    localparam logic [15:0] CANCEL_LEN = 16'h0001;

    // Timing.
    localparam int T_CLK_KHZ      = 40000;
    localparam int T_INIT_MAIN_MS = 137;
    localparam int T_INIT_FAST_MS = 2773;
    localparam int T_INIT2_MS     = 82;
    localparam int T_RESP_S       = 3;
    localparam int INIT_MAIN_CYC  = T_INIT_MAIN_MS * T_CLK_KHZ;
    localparam int INIT_FAST_CYC  = T_INIT_FAST_MS * T_CLK_KHZ;
    localparam int INIT2_CYC      = T_INIT2_MS * T_CLK_KHZ;
    localparam int RESP_CYC       = T_RESP_S * 1000 * T_CLK_KHZ;

    typedef enum logic [3:0] {
        C_NONE, C_ENC_WRITE, C_CERT_UPD, C_AUTH, C_KEY_SET, C_WRITE, C_READ,
        C_XFL_SET, C_LC_TRANSIT, C_LC_REQ, C_PL_TRANSIT, C_PL_REQ, C_AL_REQ
    } bpc_cmd_t;

    typedef enum logic [3:0] {
        S_OK, S_BUSY, S_PROT_ERR, S_PKT_ERR, S_SUM_ERR, S_CANCELED, S_ACC_ERR
    } bpc_sts_t;

    typedef struct packed {
        logic use_fast_osc;
        logic trn_lock_boot;
        logic pbp_cert;
        logic lock_bit;
        logic pbp_any;
        logic flash_protect_select;
        logic boot_swap_flag;
    } bpc_cfg_t;

endpackage : bpc_pkg

// ### logic/bpc_engine.sv
// Operation
// - Refuse encrypted write once block protection set.
// - Refuse encrypted write when both flags zero.
// - Locked protected area cannot be rewritten.
// - Protected write after block protection aborts.
// - Certificate update refused when its area protected.
// - Acceptance failure changes nothing; later failure erases.
// - Success keeps data; lock only if requested.
// - Cancel packet aborts multi-packet command to idle.
// - Cancel packet is 81 00 01 FF 00 03.
// - Cancel accepted in every multi-packet data phase.
// - Initial setting within 137 or 2773 ms.
// - Second setting step within 82 ms.
// - State and level commands answered within 3 s.
// - Packet, checksum, length error returns to idle.
`timescale 1ns/1ps
module bpc_engine #(
    parameter int          INIT_MAIN_CYC = bpc_pkg::INIT_MAIN_CYC,
    parameter int          INIT_FAST_CYC = bpc_pkg::INIT_FAST_CYC,
    parameter int          INIT2_CYC     = bpc_pkg::INIT2_CYC,
    parameter int          RESP_CYC      = bpc_pkg::RESP_CYC,
    parameter int          WORK_CYC      = 16,
    parameter logic [15:0] MAX_LEN       = 16'h0400
) (
    input  wire logic        pclk,        // 40 MHz bus clock
    input  wire logic        presetn,     // async reset, low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    output logic             locked_boot  // lifecycle in locked-boot state
);

    typedef enum logic [2:0] {E_INIT1, E_INIT2, E_IDLE, E_ENC, E_MULTI, E_TIMED} bpc_st_t;
    typedef enum logic [2:0] {P_IDLE, P_LNH, P_LNL, P_RES, P_DATA, P_SUM, P_ETX} bpc_ps_t;

    // Work is capped by the limit, so a slow setup still meets its deadline.
    function automatic logic due(input logic [26:0] cnt, input int work, input int lim);
        int w;
        w = (work < lim) ? work : lim;
        due = (cnt >= 27'(w - 1));
    endfunction : due

    bpc_st_t           st;
    bpc_st_t           next_st;
    bpc_ps_t           ps;
    bpc_pkg::bpc_sts_t sts;
    bpc_pkg::bpc_sts_t next_sts;
    bpc_pkg::bpc_cfg_t cfg;
    bpc_pkg::bpc_cmd_t last_cmd;
    logic [26:0]       tmr;
    logic [15:0]       len;
    logic [15:0]       cnt;
    logic [7:0]        sum;
    logic [7:0]        res;
    logic              sum_bad;
    logic              erased;
    logic              next_erased;
    logic              sad_undef;
    logic              next_sad;
    logic              pbp_seen;
    logic              next_pbp;
    logic              next_lock;

    // Bus decode.
    wire        acc      = psel & penable & ~pready;
    // Writes land at the completing edge, while the master still holds pwdata.
    wire        done     = psel & penable & pready;
    wire        hit      = paddr == bpc_pkg::A_CTRL || paddr == bpc_pkg::A_CFG
                           || paddr == bpc_pkg::A_RX || paddr == bpc_pkg::A_STAT;
    wire        wr_ctrl  = done & pwrite & (paddr == bpc_pkg::A_CTRL);
    wire        wr_cfg   = done & pwrite & (paddr == bpc_pkg::A_CFG);
    wire        rx_v     = done & pwrite & (paddr == bpc_pkg::A_RX);
    wire [7:0]  rx       = pwdata[7:0];
    wire        cmd_go   = wr_ctrl & (pwdata[3:0] != 4'h0);
    wire        fin      = wr_ctrl & pwdata[bpc_pkg::CTRL_FIN];
    wire bpc_pkg::bpc_cmd_t cmd_in = bpc_pkg::bpc_cmd_t'(pwdata[3:0]);
    wire        ready    = st != E_INIT1 && st != E_INIT2;
    wire [31:0] stat_w   = {20'h0, ready, locked_boot, sad_undef, erased,
                            1'b0, st, sts};
    wire [31:0] rd_mux   = paddr == bpc_pkg::A_CTRL ? {28'h0, last_cmd}
                         : paddr == bpc_pkg::A_CFG  ? {25'h0, cfg}
                         : paddr == bpc_pkg::A_STAT ? stat_w : 32'h0;

    // Packet events.
    wire [15:0] len_new  = {len[15:8], rx};
    wire        len_bad  = rx_v && ps == P_LNL && (len_new == 16'h0 || len_new > MAX_LEN);
    wire        etx_v    = rx_v && ps == P_ETX;
    wire        etx_ok   = etx_v && rx == bpc_pkg::MARK_END;
    wire        pkt_err  = len_bad || (etx_v && (rx != bpc_pkg::MARK_END || sum_bad));
    wire        pkt_ok   = etx_ok && !sum_bad;
    wire bpc_pkg::bpc_sts_t pkt_code = (etx_ok && sum_bad) ? bpc_pkg::S_SUM_ERR
                                                           : bpc_pkg::S_PKT_ERR;
    wire        cancel   = pkt_ok && len == bpc_pkg::CANCEL_LEN
                           && res == bpc_pkg::RES_ERR;
    wire        prot_pkt = pkt_ok && !cancel && res == bpc_pkg::AREA_PROT;
    wire        pbp_pkt  = pkt_ok && !cancel && res == bpc_pkg::AREA_PBP;
    wire        in_multi = st == E_ENC || st == E_MULTI;

    // Deadlines.
    wire        init1_due = due(tmr, WORK_CYC, cfg.use_fast_osc ? INIT_FAST_CYC
                                                                : INIT_MAIN_CYC);
    wire        init2_due = due(tmr, WORK_CYC, INIT2_CYC);
    wire        resp_due  = due(tmr, WORK_CYC, RESP_CYC);

    // One wait state on every access keeps read data registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~hit;
            prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg      <= '0;
            last_cmd <= bpc_pkg::C_NONE;
        end else begin
            if (wr_cfg)
                cfg <= bpc_pkg::bpc_cfg_t'(pwdata[6:0]);
            if (cmd_go && st == E_IDLE)
                last_cmd <= cmd_in;
        end
    end

    // Byte stream parser; a bad length drops the packet at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps      <= P_IDLE;
            len     <= 16'h0;
            cnt     <= 16'h0;
            sum     <= 8'h0;
            res     <= 8'h0;
            sum_bad <= 1'b0;
        end else if (rx_v) begin
            case (ps)
                P_IDLE: begin
                    sum <= 8'h0;
                    if (rx == bpc_pkg::MARK_START)
                        ps <= P_LNH;
                end
                P_LNH: begin
                    len <= {rx, 8'h00};
                    sum <= rx;
                    ps  <= P_LNL;
                end
                P_LNL: begin
                    len <= len_new;
                    sum <= sum + rx;
                    ps  <= len_bad ? P_IDLE : P_RES;
                end
                P_RES: begin
                    res <= rx;
                    sum <= sum + rx;
                    cnt <= len - 16'h1;
                    ps  <= (len == 16'h1) ? P_SUM : P_DATA;
                end
                P_DATA: begin
                    sum <= sum + rx;
                    cnt <= cnt - 16'h1;
                    if (cnt == 16'h1)
                        ps <= P_SUM;
                end
                P_SUM: begin
                    sum_bad <= (8'(sum + rx) != 8'h00);
                    ps      <= P_ETX;
                end
                default: ps <= P_IDLE;
            endcase
        end
    end

    always_comb begin
        next_st     = st;
        next_sts    = sts;
        next_lock   = locked_boot;
        next_erased = erased;
        next_sad    = sad_undef;
        next_pbp    = pbp_seen;
        case (st)
            E_INIT1: if (init1_due) next_st = E_INIT2;
            E_INIT2: if (init2_due) next_st = E_IDLE;
            E_IDLE: if (cmd_go) begin
                next_sts = bpc_pkg::S_BUSY;
                next_pbp = 1'b0;
                case (cmd_in)
                    bpc_pkg::C_ENC_WRITE: begin
                        // A refusal here leaves erased, sad_undef and locked_boot untouched; pbp_seen is still cleared.
                        if (cfg.pbp_any)
                            next_sts = bpc_pkg::S_PROT_ERR;
                        else if (!cfg.boot_swap_flag && !cfg.flash_protect_select)
                            next_sts = bpc_pkg::S_PROT_ERR;
                        else begin
                            next_st     = E_ENC;
                            next_erased = 1'b1;
                            next_sad    = 1'b0;
                        end
                    end
                    bpc_pkg::C_CERT_UPD: begin
                        if (cfg.pbp_cert)
                            next_sts = bpc_pkg::S_PROT_ERR;
                        else
                            next_st = E_MULTI;
                    end
                    bpc_pkg::C_AUTH, bpc_pkg::C_KEY_SET, bpc_pkg::C_WRITE,
                    bpc_pkg::C_READ, bpc_pkg::C_XFL_SET: next_st = E_MULTI;
                    bpc_pkg::C_LC_TRANSIT, bpc_pkg::C_LC_REQ, bpc_pkg::C_PL_TRANSIT,
                    bpc_pkg::C_PL_REQ, bpc_pkg::C_AL_REQ: next_st = E_TIMED;
                    default: next_sts = bpc_pkg::S_ACC_ERR;
                endcase
            end
            E_ENC, E_MULTI: begin
                if (pkt_err) begin
                    next_st  = E_IDLE;
                    next_sts = pkt_code;
                    next_sad = sad_undef | (st == E_ENC);
                end else if (cancel) begin
                    next_st  = E_IDLE;
                    next_sts = bpc_pkg::S_CANCELED;
                    next_sad = sad_undef | (st == E_ENC);
                end else if (st == E_ENC && prot_pkt && (cfg.lock_bit || pbp_seen)) begin
                    next_st  = E_IDLE;
                    next_sts = bpc_pkg::S_PROT_ERR;
                    next_sad = 1'b1;
                end else if (st == E_ENC && pbp_pkt) begin
                    next_pbp = 1'b1;
                end else if (fin) begin
                    next_st  = E_IDLE;
                    next_sts = bpc_pkg::S_OK;
                    if (st == E_ENC) begin
                        next_erased = 1'b0;
                        next_lock   = locked_boot | cfg.trn_lock_boot;
                    end
                end
            end
            E_TIMED: if (resp_due) begin
                next_st  = E_IDLE;
                next_sts = bpc_pkg::S_OK;
            end
            default: next_st = E_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= E_INIT1;
            sts         <= bpc_pkg::S_OK;
            locked_boot <= 1'b0;
            erased      <= 1'b0;
            sad_undef   <= 1'b0;
            pbp_seen    <= 1'b0;
        end else begin
            st          <= next_st;
            sts         <= next_sts;
            locked_boot <= next_lock;
            erased      <= next_erased;
            sad_undef   <= next_sad;
            pbp_seen    <= next_pbp;
        end
    end

    // The timer restarts on every state change and saturates.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tmr <= 27'h0;
        else if (next_st != st)
            tmr <= 27'h0;
        else if (tmr != '1)
            tmr <= tmr + 27'h1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire go_enc = st == E_IDLE && cmd_go && cmd_in == bpc_pkg::C_ENC_WRITE;

    a_enc_pbp_refuse: assert property (
        go_enc && cfg.pbp_any |=> st == E_IDLE && sts == bpc_pkg::S_PROT_ERR)
        else $error("encrypted write accepted under block protection");
    a_enc_flag_refuse: assert property (
        go_enc && !cfg.boot_swap_flag && !cfg.flash_protect_select
        |=> st == E_IDLE && sts == bpc_pkg::S_PROT_ERR)
        else $error("encrypted write accepted with both flags clear");
    a_lock_protect: assert property (
        st == E_ENC && prot_pkt && cfg.lock_bit && !pkt_err
        |=> sts == bpc_pkg::S_PROT_ERR && sad_undef)
        else $error("locked protected area rewritten");
    a_pbp_order: assert property (
        st == E_ENC && pbp_seen && prot_pkt |=> sts == bpc_pkg::S_PROT_ERR && st == E_IDLE)
        else $error("protected write after block protection not aborted");
    a_cert_refuse: assert property (
        st == E_IDLE && cmd_go && cmd_in == bpc_pkg::C_CERT_UPD && cfg.pbp_cert
        |=> sts == bpc_pkg::S_PROT_ERR && st != E_MULTI)
        else $error("certificate update accepted over protected area");
    a_refuse_stable: assert property (
        go_enc && cfg.pbp_any |=> $stable(erased) && $stable(locked_boot)
        && $stable(sad_undef))
        else $error("refused encrypted write changed state");
    a_lock_select: assert property (
        st == E_ENC && fin && !pkt_err && !cancel && !prot_pkt
        |=> !erased && locked_boot == ($past(locked_boot) | $past(cfg.trn_lock_boot)))
        else $error("completion left wrong lifecycle state");
    a_cancel_idle: assert property (
        in_multi && cancel |=> st == E_IDLE && sts == bpc_pkg::S_CANCELED)
        else $error("cancel packet did not end command");
    a_init_bound: assert property (
        st == E_INIT1 |-> tmr < 27'(cfg.use_fast_osc ? INIT_FAST_CYC : INIT_MAIN_CYC))
        else $error("initial setting overran its limit");
    a_init2_bound: assert property (
        st == E_INIT2 |-> tmr < 27'(INIT2_CYC))
        else $error("second setting step overran its limit");
    a_resp_bound: assert property (
        st == E_TIMED |-> tmr < 27'(RESP_CYC))
        else $error("command response overran its limit");
    a_err_idle: assert property (
        in_multi && pkt_err |=> st == E_IDLE && sts != bpc_pkg::S_OK)
        else $error("packet error did not return to idle");

    // Bus handshake: a one-cycle ready, and read data stays zero outside it.
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held for more than one cycle");
    a_idle_data: assert property (
        !pready |-> prdata == 32'h0)
        else $error("read data driven outside ready");
    a_lock_hold: assert property (
        locked_boot |=> locked_boot)
        else $error("locked boot state left without reset");

    c_cancel: cover property (in_multi && cancel);
    c_enc_ok: cover property (st == E_ENC && fin ##1 sts == bpc_pkg::S_OK);
    c_timed: cover property (st == E_TIMED ##1 st == E_IDLE);
    c_sum_err: cover property (in_multi && pkt_err && pkt_code == bpc_pkg::S_SUM_ERR);
    c_multi_fin: cover property (st == E_MULTI && fin);

endmodule : bpc_engine

// ### verif/bpc_host.sv
`timescale 1ns/1ps
module bpc_host (
    input  wire logic        pclk,    // bus clock
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pready,  // slave ready
    input  wire logic        pslverr, // slave error
    output logic             psel,    // select
    output logic             penable, // access phase
    output logic             pwrite,  // direction
    output logic [7:0]       paddr,   // byte address
    output logic [31:0]      pwdata,  // write data
    output logic             stuck    // no answer within the wait limit
);
    logic [31:0] last_rd;
    logic        last_err;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        stuck = 1'b0;
    end

    // A slave that never answers is treated as a failure rather than waited on forever.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n >= 64)
                stuck <= 1'b1;
        end while (pready !== 1'b1);
        last_rd = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic send_byte(input logic [7:0] b);
        xfer(1'b1, bpc_pkg::A_RX, {24'h0, b});
    endtask : send_byte

    // The length field counts the response byte as well as the body.
    task automatic send_pkt(input logic [7:0] res, input int nbody, input logic [7:0] end_b,
                            input logic [7:0] sum_adj);
        logic [15:0] len;
        logic [7:0]  sum;
        len = 16'(nbody + 1);
        sum = len[15:8] + len[7:0] + res;
        send_byte(8'h81);
        send_byte(len[15:8]);
        send_byte(len[7:0]);
        send_byte(res);
        for (int i = 0; i < nbody; i++) begin
            send_byte(8'(8'h30 + i));
            sum = sum + 8'(8'h30 + i);
        end
        send_byte(8'(-sum) + sum_adj);
        send_byte(end_b);
    endtask : send_pkt

    task automatic cancel();
        send_byte(8'h81);
        send_byte(8'h00);
        send_byte(8'h01);
        send_byte(8'hff);
        send_byte(8'h00);
        send_byte(8'h03);
    endtask : cancel
endmodule : bpc_host

// ### verif/bpc_engine_bench.sv
`timescale 1ns/1ps
module bpc_engine_bench;
    localparam int         LIMIT = 20000;
    localparam logic [3:0] IDLE  = 4'h2;
    localparam logic [7:0] CTRL  = bpc_pkg::A_CTRL;
    localparam logic [7:0] CFG   = bpc_pkg::A_CFG;
    localparam logic [7:0] STAT  = bpc_pkg::A_STAT;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, locked_boot, stuck;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          t;

    bpc_engine #(.INIT_MAIN_CYC(40), .INIT_FAST_CYC(60), .INIT2_CYC(30), .RESP_CYC(50))
    bpc_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .locked_boot(locked_boot));
    bpc_host bpc_host_i (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .stuck(stuck));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles >= LIMIT || stuck === 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : expect_eq

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bpc_host_i.xfer(1'b1, a, v);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        bpc_host_i.xfer(1'b0, a, 32'h0);
        v = bpc_host_i.last_rd;
    endtask : rd

    task automatic cmd(input logic [31:0] cfg, input logic [31:0] code);
        wr(CFG, cfg);
        wr(CTRL, code);
    endtask : cmd

    task automatic st(input logic [31:0] mask, input logic [31:0] exp, input string what);
        rd(STAT, d);
        expect_eq(d & mask, exp, what);
    endtask : st

    function automatic logic [31:0] sv(bpc_pkg::bpc_sts_t s, logic [3:0] stt, logic er,
                                       logic write_start_address);
        return {22'h0, write_start_address, er, stt, 4'(s)};
    endfunction : sv

    initial begin
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t = cycles;
        expect_eq({31'h0, locked_boot}, 32'h0, "lock after reset");
        st(32'hff0, 32'h0, "init step one");
        for (int i = 0; i < 30 && d[bpc_pkg::ST_READY] !== 1'b1; i++) begin
            rd(STAT, d);
        end
        expect_eq(d & 32'hff0, 32'h820, "idle and ready");
        expect_eq(32'(cycles - t <= 70), 32'h1, "init time");
        rd(8'h10, d);
        expect_eq({d[30:0], bpc_host_i.last_err}, 32'h1, "unmapped read");
        wr(CFG, 32'hffff_ffff);
        rd(CFG, d);
        expect_eq(d, 32'h7f, "config width");
        $display("Test done: start-up");
        cmd(32'h00, 32'h1);
        st(32'h3ff, sv(bpc_pkg::S_PROT_ERR, IDLE, 0, 0), "flags zero");
        cmd(32'h07, 32'h1);
        st(32'h3ff, sv(bpc_pkg::S_PROT_ERR, IDLE, 0, 0), "block protect");
        cmd(32'h10, 32'h2);
        st(32'h0ff, sv(bpc_pkg::S_PROT_ERR, IDLE, 0, 0), "cert protected");
        cmd(32'h02, 32'h1);
        st(32'h3f0, sv(bpc_pkg::S_OK, 4'h3, 1, 0), "enc accepted");
        bpc_host_i.cancel();
        st(32'h3ff, sv(bpc_pkg::S_CANCELED, IDLE, 1, 1), "enc canceled");
        $display("Test done: acceptance");
        cmd(32'h01, 32'h1);
        bpc_host_i.send_pkt(8'h00, 3, 8'h03, 8'h00);
        wr(CTRL, 32'h100);
        st(32'h7ff, sv(bpc_pkg::S_OK, IDLE, 0, 0), "enc done");
        expect_eq({31'h0, locked_boot}, 32'h0, "no lock unasked");
        cmd(32'h21, 32'h1);
        bpc_host_i.send_pkt(8'h01, 2, 8'h03, 8'h00);
        bpc_host_i.send_pkt(8'h02, 2, 8'h03, 8'h00);
        wr(CTRL, 32'h100);
        st(32'h7ff, sv(bpc_pkg::S_OK, IDLE, 0, 0) | 32'h400, "enc locked");
        expect_eq({31'h0, locked_boot}, 32'h1, "lock requested");
        cmd(32'h09, 32'h1);
        bpc_host_i.send_pkt(8'h01, 2, 8'h03, 8'h00);
        st(32'h3ff, sv(bpc_pkg::S_PROT_ERR, IDLE, 1, 1), "lock bit");
        cmd(32'h01, 32'h1);
        bpc_host_i.send_pkt(8'h02, 2, 8'h03, 8'h00);
        bpc_host_i.send_pkt(8'h01, 2, 8'h03, 8'h00);
        st(32'h3ff, sv(bpc_pkg::S_PROT_ERR, IDLE, 1, 1), "late protected");
        $display("Test done: encrypted write");
        for (int c = 2; c < 8; c++) begin
            cmd(32'h00, 32'(c));
            st(32'h0f0, 32'h40, "multi entered");
            bpc_host_i.cancel();
            st(32'h0ff, sv(bpc_pkg::S_CANCELED, IDLE, 0, 0), "multi canceled");
        end
        cmd(32'h00, 32'h7);
        bpc_host_i.send_pkt(8'h00, 4, 8'h03, 8'h00);
        wr(CTRL, 32'h100);
        st(32'h0ff, sv(bpc_pkg::S_OK, IDLE, 0, 0), "driver loaded");
        cmd(32'h00, 32'h5);
        bpc_host_i.send_pkt(8'h00, 2, 8'h04, 8'h01);
        st(32'h0ff, sv(bpc_pkg::S_PKT_ERR, IDLE, 0, 0), "bad end");
        cmd(32'h00, 32'h5);
        bpc_host_i.send_pkt(8'h00, 2, 8'h03, 8'h01);
        st(32'h0ff, sv(bpc_pkg::S_SUM_ERR, IDLE, 0, 0), "bad sum");
        cmd(32'h00, 32'h5);
        wr(bpc_pkg::A_RX, 32'h81);
        wr(bpc_pkg::A_RX, 32'h00);
        wr(bpc_pkg::A_RX, 32'h00);
        st(32'h0ff, sv(bpc_pkg::S_PKT_ERR, IDLE, 0, 0), "zero length");
        $display("Test done: cancel and errors");
        for (int c = 8; c < 13; c++) begin
            wr(CTRL, 32'(c));
            t = cycles;
            st(32'h0f0, 32'h50, "timed busy");
            for (int i = 0; i < 40 && d[7:4] !== IDLE; i++) begin
                rd(STAT, d);
            end
            expect_eq(d & 32'hff, sv(bpc_pkg::S_OK, IDLE, 0, 0), "timed answer");
            expect_eq(32'(cycles - t <= 50), 32'h1, "response time");
        end
        rd(CTRL, d);
        expect_eq(d & 32'hf, 32'hc, "last command");
        wr(CTRL, 32'hd);
        st(32'h0ff, sv(bpc_pkg::S_ACC_ERR, IDLE, 0, 0), "unknown code");
        $display("Test done: timed commands");
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t = cycles;
        wr(CFG, 32'h40);
        st(32'hff0, 32'h0, "reset again");
        for (int i = 0; i < 30 && d[bpc_pkg::ST_READY] !== 1'b1; i++) begin
            rd(STAT, d);
        end
        expect_eq(d & 32'hff0, 32'h820, "fast osc ready");
        expect_eq(32'(cycles - t <= 90), 32'h1, "fast osc init time");
        $display("Test done: reset in mid-run");
        close_out();
    end
endmodule : bpc_engine_bench
